// File: hid_pkg.sv
// shared constants and types for the hardware integer divider
package hid_pkg;
  localparam int unsigned DW = 32;
  localparam int unsigned CALC_CYCLES = 8;
  localparam logic [3:0] CNT_DONE = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [DW-1:0] WORD_ZERO = 32'h00000000;

  typedef enum logic {HID_IDLE, HID_BUSY} hid_state_t;

  // control written by software
  typedef struct packed {
    logic start;
    logic signed_mode;
  } hid_ctrl_t;

  // status read by software
  typedef struct packed {
    logic busy;
    logic done;
    logic div_zero;
  } hid_stat_t;
endpackage

// File: hid_divider.sv
// hardware integer divider with eight cycle latency and plain control ports
// Overview of operation
// RULE1: divides 32-bit signed or unsigned operands and truncates the quotient toward zero.
// RULE2: each operand write is captured into its register in one clock cycle; the code ignores writes made while a division is busy.
// RULE3: software starts every division with the start bit; the block never starts on its own.
// RULE4: exactly eight cycles after a start the completion flag sets and results are valid.
// RULE5: a start with a zero divisor register sets the divide-by-zero flag.
// RULE6: quotient and remainder are readable, and a new start clears both flags.
`timescale 1ns/1ps
module hid_divider (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // operand writes
  input wire logic dividend_we,
  input wire logic [31:0] dividend_wdata,
  input wire logic divisor_we,
  input wire logic [31:0] divisor_wdata,
  // control
  input wire hid_pkg::hid_ctrl_t ctrl,
  // operands and results
  output logic [31:0] dividend_q,
  output logic [31:0] divisor_q,
  output logic [31:0] quotient,
  output logic [31:0] remainder,
  // status
  output hid_pkg::hid_stat_t stat
);

  logic [31:0] dvd_r, dvd_nxt;
  logic [31:0] dvs_r, dvs_nxt;
  logic [31:0] quo_r, quo_nxt;
  logic [31:0] rem_r, rem_nxt;
  logic [31:0] quo_calc, rem_calc;
  logic [31:0] a_mag, b_mag, uq, ur;
  logic sgn_r, sgn_nxt;
  logic done_r, done_nxt;
  logic dz_r, dz_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  hid_pkg::hid_state_t st_r, st_nxt;

  // truncating divide on magnitudes, sign restored afterwards
  always_comb begin
    a_mag = (sgn_r && dvd_r[31]) ? 32'(-dvd_r) : dvd_r;
    b_mag = (sgn_r && dvs_r[31]) ? 32'(-dvs_r) : dvs_r;
    uq = (b_mag == hid_pkg::WORD_ZERO) ? hid_pkg::WORD_ZERO : a_mag / b_mag;
    ur = (b_mag == hid_pkg::WORD_ZERO) ? a_mag : a_mag % b_mag;
    // RULE1: quotient sign from xor, remainder follows dividend
    quo_calc = (sgn_r && (dvd_r[31] ^ dvs_r[31])) ? 32'(-uq) : uq;
    rem_calc = (sgn_r && dvd_r[31]) ? 32'(-ur) : ur;
  end

  // next state of operands, sequencer and flags
  always_comb begin
    dvd_nxt = dvd_r;
    dvs_nxt = dvs_r;
    quo_nxt = quo_r;
    rem_nxt = rem_r;
    sgn_nxt = sgn_r;
    done_nxt = done_r;
    dz_nxt = dz_r;
    cnt_nxt = cnt_r;
    st_nxt = st_r;
    // RULE2: single cycle operand load, ignored while busy
    if (st_r == hid_pkg::HID_IDLE) begin
      if (dividend_we) begin
        dvd_nxt = dividend_wdata;
      end
      if (divisor_we) begin
        dvs_nxt = divisor_wdata;
      end
    end
    case (st_r)
      hid_pkg::HID_IDLE: begin
        // RULE3: only the software start bit launches a division
        if (ctrl.start) begin
          // RULE6: new start clears both flags
          done_nxt = 1'h0;
          dz_nxt = 1'h0;
          sgn_nxt = ctrl.signed_mode;
          cnt_nxt = hid_pkg::CNT_ONE;
          st_nxt = hid_pkg::HID_BUSY;
        end
      end
      hid_pkg::HID_BUSY: begin
        // counter holds how many edges have passed, the start edge included;
        // operands stay frozen meanwhile, so completion sees the start's divisor
        cnt_nxt = cnt_r + hid_pkg::CNT_ONE;
        // RULE4: flag and results land on the eighth edge after the start
        if (cnt_r == hid_pkg::CNT_DONE) begin
          done_nxt = 1'h1;
          // RULE5: zero divisor raises the error flag
          dz_nxt = (dvs_r == hid_pkg::WORD_ZERO);
          quo_nxt = quo_calc;
          rem_nxt = rem_calc;
          cnt_nxt = hid_pkg::CNT_ZERO;
          st_nxt = hid_pkg::HID_IDLE;
        end
      end
      default: begin
        st_nxt = hid_pkg::HID_IDLE;
        cnt_nxt = hid_pkg::CNT_ZERO;
      end
    endcase
  end

  // state registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dvd_r <= hid_pkg::WORD_ZERO;
      dvs_r <= hid_pkg::WORD_ZERO;
      quo_r <= hid_pkg::WORD_ZERO;
      rem_r <= hid_pkg::WORD_ZERO;
      sgn_r <= 1'h0;
      done_r <= 1'h0;
      dz_r <= 1'h0;
      cnt_r <= hid_pkg::CNT_ZERO;
      st_r <= hid_pkg::HID_IDLE;
    end else begin
      dvd_r <= dvd_nxt;
      dvs_r <= dvs_nxt;
      quo_r <= quo_nxt;
      rem_r <= rem_nxt;
      sgn_r <= sgn_nxt;
      done_r <= done_nxt;
      dz_r <= dz_nxt;
      cnt_r <= cnt_nxt;
      st_r <= st_nxt;
    end
  end

  // outputs straight from registers
  assign dividend_q = dvd_r;
  assign divisor_q = dvs_r;
  assign quotient = quo_r;
  assign remainder = rem_r;
  assign stat = {st_r == hid_pkg::HID_BUSY, done_r, dz_r};

  // a start is accepted only while idle
  logic start_ok;
  assign start_ok = ctrl.start && (st_r == hid_pkg::HID_IDLE);

  // RULE4 done after eight
  a_done_eight: assert property (@(posedge sys_clk) disable iff (rst) // RULE4
    start_ok |=> !done_r [*8] ##1 done_r)
    else $error("completion flag not set exactly eight cycles after start");

  // RULE4 busy eight cycles
  a_busy_count: assert property (@(posedge sys_clk) disable iff (rst) // RULE4
    start_ok |=> stat.busy [*8] ##1 !stat.busy)
    else $error("busy not held for exactly eight cycles");

  // RULE4 busy ends done
  a_busy_done: assert property (@(posedge sys_clk) disable iff (rst) // RULE4
    $fell(stat.busy) |-> done_r)
    else $error("busy ended without completion flag");

  // RULE6 start clears flags
  a_flag_clear: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
    start_ok |=> !done_r && !dz_r)
    else $error("flags not cleared by a new start");

  // RULE6 flag stays set
  a_done_sticky: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
    done_r && !start_ok |=> done_r)
    else $error("completion flag dropped without a start");

  // RULE5 zero divisor flag
  a_zero_flag: assert property (@(posedge sys_clk) disable iff (rst) // RULE5
    start_ok ##1 (dvs_r == hid_pkg::WORD_ZERO) |-> ##8 dz_r)
    else $error("divide-by-zero flag missing");

  // RULE5 nonzero divisor clear
  a_nonzero_flag: assert property (@(posedge sys_clk) disable iff (rst) // RULE5
    start_ok ##1 (dvs_r != hid_pkg::WORD_ZERO) |-> ##8 !dz_r)
    else $error("divide-by-zero flag set for nonzero divisor");

  // RULE5 zero divisor results
  a_zero_result: assert property (@(posedge sys_clk) disable iff (rst) // RULE5
    $rose(done_r) && dz_r |-> quo_r == hid_pkg::WORD_ZERO && rem_r == dvd_r)
    else $error("divide-by-zero results wrong");

  // RULE3 no self start
  a_no_self: assert property (@(posedge sys_clk) disable iff (rst) // RULE3
    !stat.busy && !ctrl.start |=> !stat.busy)
    else $error("division began without start");

  // RULE2 dividend single load
  a_load_one: assert property (@(posedge sys_clk) disable iff (rst) // RULE2
    dividend_we && !stat.busy |=> dvd_r == $past(dividend_wdata))
    else $error("dividend not loaded in one cycle");

  // RULE2 divisor single load
  a_load_dvs: assert property (@(posedge sys_clk) disable iff (rst) // RULE2
    divisor_we && !stat.busy |=> dvs_r == $past(divisor_wdata))
    else $error("divisor not loaded in one cycle");

  // RULE2 operands frozen busy
  a_ops_frozen: assert property (@(posedge sys_clk) disable iff (rst) // RULE2
    stat.busy |=> $stable(dvd_r) && $stable(dvs_r))
    else $error("operand changed during a division");

  // RULE1 mode taken start
  a_mode_take: assert property (@(posedge sys_clk) disable iff (rst) // RULE1
    start_ok |=> sgn_r == $past(ctrl.signed_mode))
    else $error("signed mode not taken with start");

  // RULE1 unsigned result check
  a_uns_result: assert property (@(posedge sys_clk) disable iff (rst) // RULE1
    $rose(done_r) && !sgn_r && dvs_r != hid_pkg::WORD_ZERO |->
      quo_r * dvs_r + rem_r == dvd_r && rem_r < dvs_r)
    else $error("unsigned result wrong");

  // RULE1 signed truncation check
  a_sgn_trunc: assert property (@(posedge sys_clk) disable iff (rst) // RULE1
    $rose(done_r) && sgn_r && dvs_r != hid_pkg::WORD_ZERO |->
      32'($signed(quo_r) * $signed(dvs_r) + $signed(rem_r)) == dvd_r
      && (rem_r == hid_pkg::WORD_ZERO || rem_r[31] == dvd_r[31]))
    else $error("signed result not truncated toward zero");

  // RULE6 results held idle
  a_hold_res: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
    done_r && !start_ok |=> $stable(quo_r) && $stable(rem_r))
    else $error("results changed without a start");

endmodule

// File: tb.sv
// self-checking testbench for the hardware integer divider
`timescale 1ns/1ps
module tb;
  logic sys_clk, rst, dividend_we, divisor_we;
  logic [31:0] dividend_wdata, divisor_wdata, dividend_q, divisor_q, quotient, remainder;
  hid_pkg::hid_ctrl_t ctrl;
  hid_pkg::hid_stat_t stat;
  int n_fail, n_tests;
  integer seed;
  hid_divider u_dut (.sys_clk(sys_clk), .rst(rst), .dividend_we(dividend_we),
    .dividend_wdata(dividend_wdata), .divisor_we(divisor_we), .divisor_wdata(divisor_wdata),
    .ctrl(ctrl), .dividend_q(dividend_q), .divisor_q(divisor_q), .quotient(quotient),
    .remainder(remainder), .stat(stat));
  // free-running clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // inputs always change just after the rising edge
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  // load operands, start, and compare against the integer model
  task automatic run(input logic [31:0] a, input logic [31:0] b, input logic sm);
    logic [31:0] eq, er;
    if (b == 32'h0) begin
      eq = 32'h0;
      er = a;
    end else if (sm) begin
      eq = $signed(a) / $signed(b);
      er = $signed(a) % $signed(b);
    end else begin
      eq = a / b;
      er = a % b;
    end
    dividend_we = 1'h1;
    dividend_wdata = a;
    divisor_we = 1'h1;
    divisor_wdata = b;
    step();
    dividend_we = 1'h0;
    divisor_we = 1'h0;
    chk(dividend_q, a);
    chk(divisor_q, b);
    ctrl = {1'h1, sm};
    step();
    ctrl = 2'h0;
    // busy with both flags low until the eighth edge
    for (int k = 0; k < 8; k++) begin
      chk({29'h0, stat}, 32'h4);
      step();
    end
    chk({31'h0, stat.done}, 32'h1);
    chk({31'h0, stat.busy}, 32'h0);
    chk({31'h0, stat.div_zero}, {31'h0, b == 32'h0});
    chk(quotient, eq);
    chk(remainder, er);
    $display("test a=%h b=%h signed=%0d done", a, b, sm);
  endtask
  // main sequence
  initial begin
    seed = 32'hc7ed5d4d;
    n_fail = 0;
    n_tests = 0;
    rst = 1'h1;
    dividend_we = 1'h0;
    divisor_we = 1'h0;
    dividend_wdata = 32'h0;
    divisor_wdata = 32'h0;
    ctrl = 2'h0;
    repeat (12) @(posedge sys_clk);
    #1;
    rst = 1'h0;
    // without a start the block stays idle
    repeat (4) step();
    chk({29'h0, stat}, 32'h0);
    $display("test idle done");
    run(32'h00000007, 32'h00000002, 1'b0);
    run(32'hfffffff9, 32'h00000002, 1'b1);
    run(32'h00000007, 32'hfffffffe, 1'b1);
    run(32'hfffffff9, 32'h00000002, 1'b0);
    run(32'h0000abcd, 32'h00000000, 1'b1);
    run(32'h12345678, 32'h00000003, 1'b0);
    for (int i = 0; i < 40; i++) begin
      run($random(seed), $random(seed) >>> (i % 32), i[0]);
    end
    // a write and a start while busy are ignored: 100 / 5 still results
    dividend_we = 1'h1;
    dividend_wdata = 32'h00000064;
    divisor_we = 1'h1;
    divisor_wdata = 32'h00000005;
    step();
    dividend_we = 1'h0;
    divisor_we = 1'h0;
    ctrl = 2'h2;
    step();
    dividend_we = 1'h1;
    dividend_wdata = 32'h00000032;
    step();
    dividend_we = 1'h0;
    ctrl = 2'h0;
    repeat (7) step();
    chk({29'h0, stat}, 32'h2);
    chk(quotient, 32'h00000014);
    chk(dividend_q, 32'h00000064);
    $display("test busy writes done");
    // reset in the middle of a division clears everything and stays idle
    ctrl = 2'h2;
    step();
    ctrl = 2'h0;
    repeat (3) step();
    rst = 1'h1;
    step();
    chk({29'h0, stat}, 32'h0);
    chk(quotient, 32'h0);
    chk(dividend_q, 32'h0);
    rst = 1'h0;
    repeat (9) step();
    chk({29'h0, stat}, 32'h0);
    $display("test reset done");
    final_report();
  end
endmodule
